// ===== logic/ibcrc_clk_if.sv
// link between the word engine and the serial clock generator
`timescale 1ns/1ns
interface ibcrc_clk_if;
  logic       run;
  logic       hold;
  logic [2:0] rate;
  logic       scl_bus;
  logic       drive_low;
  logic       high_done;
  modport ctl (output run, hold, rate, scl_bus, input drive_low, high_done);
  modport gen (input run, hold, rate, scl_bus, output drive_low, high_done);
endinterface : ibcrc_clk_if

// ===== logic/ibcrc_pkg.sv
// types and decode functions of the i2c bit engine
`include "ibcrc_regs.svh"
package ibcrc_pkg;
  typedef enum logic [3:0] {G_IDLE = 4'h1, G_LOW = 4'h2, G_WAIT = 4'h4, G_HIGH = 4'h8} ibcrc_gst_t;

  function automatic logic [3:0] ibcrc_nbits(input logic [2:0] bc);
    return (bc == 3'h0) ? 4'h8 : {1'b0, bc};
  endfunction : ibcrc_nbits

  function automatic logic [3:0] ibcrc_total(input logic [2:0] bc, input logic ack);
    return ibcrc_nbits(bc) + {3'h0, ack};
  endfunction : ibcrc_total

  function automatic logic ibcrc_mapped(input logic [7:0] a);
    return a == `IBC_OFF_CTRL1 || a == `IBC_OFF_CTRL2 || a == `IBC_OFF_STAT ||
           a == `IBC_OFF_ADDR || a == `IBC_OFF_DATA;
  endfunction : ibcrc_mapped

  function automatic logic [17:0] ibcrc_rate(input logic [2:0] r);
    case (r)
      3'h0: return {`IBC_THIGH_0, `IBC_TLOW_0};
      3'h1: return {`IBC_THIGH_1, `IBC_TLOW_1};
      3'h2: return {`IBC_THIGH_2, `IBC_TLOW_2};
      3'h3: return {`IBC_THIGH_3, `IBC_TLOW_3};
      3'h4: return {`IBC_THIGH_4, `IBC_TLOW_4};
      3'h5: return {`IBC_THIGH_5, `IBC_TLOW_5};
      3'h6: return {`IBC_THIGH_6, `IBC_TLOW_6};
      default: return {`IBC_THIGH_7, `IBC_TLOW_7};
    endcase
  endfunction : ibcrc_rate
endpackage : ibcrc_pkg

// ===== logic/ibcrc_regs.svh
// register offsets, field positions, reset values and clock counts of the i2c bit engine
// Function
// - word is 1 to 8 bits plus ack clock
// - start clears bit count to 000
// - master transmitter releases data during ack
// - master receiver drives ack low
// - slave acks own address or general call
// - matched slave acks as receiver, releases transmitting
// - no ack clock or level without ack mode
// - master high/low periods from rate table
// - start hold and stop setup one high period
// - slave releases clock one low period later
// - bus clock low during high restarts count
// - high count starts only on bus high
// - role bits written, cleared on stop/loss
// - slave transmit bit follows direction bit
// - master transmit bit inverts acked direction
// - detect-disable leaves slave transmit bit alone
// - free format sees no address or direction
// - transfer irq at end of word
// - irq clears pending, clock held low meanwhile
`ifndef IBCRC_REGS_SVH
`define IBCRC_REGS_SVH
`define IBC_OFF_CTRL1   8'h00
`define IBC_OFF_CTRL2   8'h04
`define IBC_OFF_STAT    8'h08
`define IBC_OFF_ADDR    8'h0c
`define IBC_OFF_DATA    8'h10
`define IBC_C1_BC       7:5
`define IBC_C1_ACK      4
`define IBC_C1_NODET    3
`define IBC_C1_RATE     2:0
`define IBC_C2_MST      7
`define IBC_C2_TRX      6
`define IBC_C2_BUSY     5
`define IBC_C2_PEND     4
`define IBC_ADR_FREE    0
`define IBC_C1_RST      8'h00
`define IBC_ADR_RST     8'h00
`define IBC_PEND_RST    1'b1
`define IBC_RESP_OKAY   2'h0
`define IBC_RESP_SLVERR 2'h2
`define IBC_THIGH_0     9'h009
`define IBC_THIGH_1     9'h00b
`define IBC_THIGH_2     9'h00f
`define IBC_THIGH_3     9'h017
`define IBC_THIGH_4     9'h027
`define IBC_THIGH_5     9'h047
`define IBC_THIGH_6     9'h087
`define IBC_THIGH_7     9'h107
`define IBC_TLOW_0      9'h00c
`define IBC_TLOW_1      9'h00e
`define IBC_TLOW_2      9'h012
`define IBC_TLOW_3      9'h01a
`define IBC_TLOW_4      9'h02a
`define IBC_TLOW_5      9'h04a
`define IBC_TLOW_6      9'h08a
`define IBC_TLOW_7      9'h10a
`endif

// ===== logic/ibcrc_scl_gen.sv
// serial clock generator: high/low counts, clock synchronisation and slave hold
`timescale 1ns/1ns
module ibcrc_scl_gen
  import ibcrc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  ibcrc_clk_if.gen cif
);
  ibcrc_gst_t st_q, st_d;
  logic [8:0] cnt_q, cnt_d, m_w, n_w;
  logic       done_q, done_d;

  assign {m_w, n_w} = ibcrc_rate(cif.rate);
  assign cif.drive_low = (st_q == G_LOW);
  assign cif.high_done = done_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 9'h001;
    done_d = 1'b0;
    case (st_q)
      G_IDLE: begin
        cnt_d = 9'h000;
        if (cif.hold) st_d = G_LOW;
        else if (cif.run && cif.scl_bus) st_d = G_HIGH;
      end
      G_LOW: begin
        if (cif.hold) cnt_d = 9'h000;
        else if (cnt_q >= n_w - 9'h001) begin
          cnt_d = 9'h000;
          st_d = G_WAIT;
        end
      end
      G_WAIT: begin
        cnt_d = 9'h000;
        if (cif.scl_bus) st_d = G_HIGH;
      end
      G_HIGH: begin
        if (!cif.scl_bus) begin
          cnt_d = 9'h000;
          st_d = cif.run ? G_LOW : G_IDLE;
        end else if (cnt_q >= m_w - 9'h001) begin
          cnt_d = 9'h000;
          done_d = 1'b1;
          st_d = cif.run ? G_LOW : G_IDLE;
        end
      end
      default: begin
        st_d = G_IDLE;
        cnt_d = 9'h000;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= G_IDLE;
      cnt_q <= 9'h000;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  property p_sync_restart;
    @(posedge aclk) disable iff (!aresetn)
    st_q == G_HIGH && !cif.scl_bus && cif.run |=> st_q == G_LOW && cnt_q == 9'h000;
  endproperty
  a_sync_restart: assert property (p_sync_restart) else $error("high count not restarted");
  property p_wait_bus;
    @(posedge aclk) disable iff (!aresetn)
    st_q == G_WAIT && !cif.scl_bus |=> st_q == G_WAIT;
  endproperty
  a_wait_bus: assert property (p_wait_bus) else $error("high count began on low bus");
  property p_low_len;
    @(posedge aclk) disable iff (!aresetn)
    st_q == G_LOW && cif.hold ##1 !cif.hold |-> st_q == G_LOW [*2];
  endproperty
  a_low_len: assert property (p_low_len) else $error("clock released early");
  property p_high_len;
    @(posedge aclk) disable iff (!aresetn)
    st_q == G_HIGH && cif.scl_bus && cnt_q < m_w - 9'h001 |=> st_q == G_HIGH;
  endproperty
  a_high_len: assert property (p_high_len) else $error("high period cut short");
endmodule : ibcrc_scl_gen

// ===== logic/ibcrc_top.sv
// i2c bit and clock engine with role control, reached over axi4-lite
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "ibcrc_regs.svh"
module ibcrc_top
  import ibcrc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        clock_line_pin_level,
  output logic             clock_line_pin_value,
  output logic             clock_line_pin_enable,
  input  wire logic        data_line_pin_level,
  output logic             data_line_pin_value,
  output logic             data_line_pin_enable,
  output logic             transfer_irq
);
  ibcrc_clk_if cif ();

  logic       awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] rdata_q, awa_q, wd_q;
  logic       aw_got_q, w_got_q, wbe_q;
  logic       scl_s1_q, scl_s2_q, scl_p_q, sda_s1_q, sda_s2_q, sda_p_q;
  logic [7:0] c1_q, adr_q, tx_q, rx_q, rxbuf_q;
  logic [3:0] idx_q;
  logic       mst_q, trx_q, busy_q, pend_q, al_q, aas_q, ad0_q, lrb_q;
  logic       adr_ph_q, match_q, sda_low_q, run_q, stop_q, irq_q, scl_oe_q;

  // register access strobes
  wire        wr_fire = aw_got_q && w_got_q && !bvalid_q;
  wire        wr_c1   = wr_fire && wbe_q && awa_q == `IBC_OFF_CTRL1;
  wire        wr_c2   = wr_fire && wbe_q && awa_q == `IBC_OFF_CTRL2;
  wire        wr_adr  = wr_fire && wbe_q && awa_q == `IBC_OFF_ADDR;
  wire        wr_dat  = wr_fire && wbe_q && awa_q == `IBC_OFF_DATA;
  wire        rd_take = s_axi_arvalid && arready_q;
  wire        rd_dat  = rd_take && s_axi_araddr == `IBC_OFF_DATA;
  wire [7:0]  stat_w  = {mst_q, trx_q, busy_q, pend_q, al_q, aas_q, ad0_q, lrb_q};
  wire [7:0]  rd_w    = s_axi_araddr == `IBC_OFF_CTRL1 ? c1_q :
                        s_axi_araddr == `IBC_OFF_STAT  ? stat_w :
                        s_axi_araddr == `IBC_OFF_ADDR  ? adr_q :
                        s_axi_araddr == `IBC_OFF_DATA  ? rxbuf_q : 8'h00;

  // bus conditions seen on the synchronised lines
  wire        scl_rise  = scl_s2_q && !scl_p_q;
  wire        scl_fall  = !scl_s2_q && scl_p_q;
  wire        start_det = scl_s2_q && scl_p_q && sda_p_q && !sda_s2_q;
  wire        stop_det  = scl_s2_q && scl_p_q && !sda_p_q && sda_s2_q;

  // word decode
  wire        ack_on   = c1_q[`IBC_C1_ACK];
  wire        free_w   = adr_q[`IBC_ADR_FREE];
  wire [3:0]  nbits_w  = ibcrc_nbits(c1_q[`IBC_C1_BC]);
  wire [3:0]  total_w  = ibcrc_total(c1_q[`IBC_C1_BC], ack_on);
  wire        word_end = scl_fall && busy_q && idx_q == total_w;
  wire        ack_pt   = scl_fall && busy_q && ack_on && idx_q == nbits_w;
  wire        gen_call = rx_q == 8'h00;
  wire        hit_now  = scl_fall && busy_q && adr_ph_q && !mst_q && !c1_q[`IBC_C1_NODET] && !free_w &&
                         idx_q == nbits_w && (gen_call || rx_q[7:1] == adr_q[7:1]);
  wire        tx_act   = trx_q && (mst_q || match_q);
  wire        ack_low  = mst_q ? !trx_q : (hit_now || (match_q && !adr_ph_q && !trx_q));
  wire        sda_next = ack_pt ? ack_low : (tx_act && idx_q < nbits_w && !tx_q[~idx_q[2:0]]);
  wire        irq_ev   = word_end && (mst_q || match_q || hit_now || free_w);
  wire        lost     = scl_rise && busy_q && mst_q && tx_act && idx_q < nbits_w && !sda_low_q && !sda_s2_q;
  wire        m_acked  = word_end && mst_q && adr_ph_q && ack_on && !lrb_q;
  wire        cmd_start = wr_c2 && wd_q[`IBC_C2_MST] && wd_q[`IBC_C2_BUSY] && !busy_q;
  wire        cmd_stop  = wr_c2 && wd_q[`IBC_C2_MST] && !wd_q[`IBC_C2_BUSY] && busy_q && mst_q;

  assign cif.run     = run_q;
  assign cif.hold    = busy_q && !pend_q;
  assign cif.rate    = c1_q[`IBC_C1_RATE];
  assign cif.scl_bus = scl_s2_q;

  ibcrc_scl_gen u_gen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cif     (cif)
  );

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {24'h000000, rdata_q};
  assign clock_line_pin_value  = 1'b0;
  assign clock_line_pin_enable = scl_oe_q;
  assign data_line_pin_value   = 1'b0;
  assign data_line_pin_enable  = sda_low_q;
  assign transfer_irq          = irq_q;

  // axi4-lite write path: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `IBC_RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 8'h00;
      wbe_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_got_q <= 1'b1;
        awa_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        w_got_q <= 1'b1;
        wd_q <= s_axi_wdata[7:0];
        wbe_q <= s_axi_wstrb[0];
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= ibcrc_mapped(awa_q) ? `IBC_RESP_OKAY : `IBC_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // axi4-lite read path: one answer per address, next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `IBC_RESP_OKAY;
      rdata_q <= 8'h00;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_w;
      rresp_q <= ibcrc_mapped(s_axi_araddr) ? `IBC_RESP_OKAY : `IBC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // pins cross into aclk through two flops; a third flop keeps the previous level for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_p_q} <= 3'h7;
      scl_oe_q <= 1'b0;
    end else begin
      {scl_s1_q, scl_s2_q, scl_p_q} <= {clock_line_pin_level, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_p_q} <= {data_line_pin_level, sda_s1_q, sda_s2_q};
      scl_oe_q <= cif.drive_low;
    end
  end

  // configuration; a start on the bus forces 8-bit words for the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c1_q <= `IBC_C1_RST;
      adr_q <= `IBC_ADR_RST;
    end else begin
      if (wr_c1) c1_q <= wd_q;
      if (start_det) c1_q[`IBC_C1_BC] <= 3'h0;
      if (wr_adr) adr_q <= wd_q;
    end
  end

  // role bits: hardware clears win over a simultaneous software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mst_q <= 1'b0;
      trx_q <= 1'b0;
    end else begin
      if (wr_c2) begin
        mst_q <= wd_q[`IBC_C2_MST];
        trx_q <= wd_q[`IBC_C2_TRX];
      end
      if (hit_now) trx_q <= rx_q[0];
      if (m_acked && !free_w) trx_q <= !tx_q[0];
      if (stop_det || lost) begin
        mst_q <= 1'b0;
        trx_q <= 1'b0;
      end
    end
  end

  // bit counter and shift registers driven by bus clock edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_q <= 4'h0;
      rx_q <= 8'h00;
      rxbuf_q <= 8'h00;
      lrb_q <= 1'b0;
    end else begin
      if (start_det || word_end) idx_q <= 4'h0;
      else if (scl_rise && busy_q) idx_q <= idx_q + 4'h1;
      if (scl_rise && busy_q && idx_q < nbits_w) rx_q <= {rx_q[6:0], sda_s2_q};
      if (scl_rise) lrb_q <= sda_s2_q;
      if (word_end) rxbuf_q <= rx_q;
    end
  end

  // transmit data and transfer-pending flag; a software set wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q <= 8'h00;
      pend_q <= `IBC_PEND_RST;
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_ev;
      if (irq_ev) pend_q <= 1'b0;
      if (wr_dat || (wr_c2 && wd_q[`IBC_C2_PEND])) pend_q <= 1'b1;
      if (wr_dat) tx_q <= wd_q;
    end
  end

  // bus state, address phase and match tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      adr_ph_q <= 1'b0;
      match_q <= 1'b0;
      aas_q <= 1'b0;
      ad0_q <= 1'b0;
      al_q <= 1'b0;
    end else begin
      if (wr_dat || rd_dat) aas_q <= 1'b0;
      if (wr_dat || rd_dat || wr_c2) al_q <= 1'b0;
      if (lost) al_q <= 1'b1;
      if (word_end) adr_ph_q <= 1'b0;
      if (hit_now) begin
        match_q <= 1'b1;
        aas_q <= 1'b1;
        ad0_q <= gen_call;
      end
      if (word_end && free_w && !mst_q && !match_q) begin
        match_q <= 1'b1;
        aas_q <= 1'b1;
      end
      if (start_det) begin
        busy_q <= 1'b1;
        adr_ph_q <= !free_w;
        match_q <= 1'b0;
        ad0_q <= 1'b0;
      end
      if (stop_det) begin
        busy_q <= 1'b0;
        adr_ph_q <= 1'b0;
        match_q <= 1'b0;
        ad0_q <= 1'b0;
      end
    end
  end

  // data line drive and master start/stop sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_low_q <= 1'b0;
      run_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (scl_fall && busy_q) sda_low_q <= sda_next;
      if (wr_dat && busy_q && tx_act && idx_q == 4'h0) sda_low_q <= !wd_q[7];
      if (cmd_start) begin
        sda_low_q <= 1'b1;
        run_q <= 1'b1;
      end
      if (cmd_stop) begin
        sda_low_q <= 1'b1;
        run_q <= 1'b0;
        stop_q <= 1'b1;
      end
      if (cif.high_done && stop_q) begin
        sda_low_q <= 1'b0;
        stop_q <= 1'b0;
      end
      if (lost || stop_det) begin
        sda_low_q <= 1'b0;
        run_q <= 1'b0;
        stop_q <= 1'b0;
      end
    end
  end

  property p_bc_clear;
    @(posedge aclk) disable iff (!aresetn)
    start_det |=> c1_q[`IBC_C1_BC] == 3'h0 && nbits_w == 4'h8;
  endproperty
  a_bc_clear: assert property (p_bc_clear) else $error("bit count not cleared by start");
  property p_irq_end;
    @(posedge aclk) disable iff (!aresetn)
    word_end && mst_q |=> transfer_irq && (!pend_q || $past(wr_dat));
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("no irq at word end");
  property p_hold_low;
    @(posedge aclk) disable iff (!aresetn)
    busy_q && !pend_q [*3] |-> clock_line_pin_enable;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("clock not held while pending clear");
  property p_ack_mrx;
    @(posedge aclk) disable iff (!aresetn)
    ack_pt && mst_q && !trx_q |=> data_line_pin_enable;
  endproperty
  a_ack_mrx: assert property (p_ack_mrx) else $error("master receiver gave no ack");
  property p_ack_mtx;
    @(posedge aclk) disable iff (!aresetn)
    ack_pt && mst_q && trx_q && !cmd_start && !cmd_stop |=> !data_line_pin_enable;
  endproperty
  a_ack_mtx: assert property (p_ack_mtx) else $error("master transmitter held data in ack");
  property p_no_ack;
    @(posedge aclk) disable iff (!aresetn)
    scl_fall && busy_q && !ack_on && idx_q == nbits_w |-> word_end;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("ack clock counted in non-ack mode");
  property p_stop_clr;
    @(posedge aclk) disable iff (!aresetn)
    stop_det |=> !mst_q && !trx_q && !busy_q;
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("roles kept after stop");
  property p_slv_trx;
    @(posedge aclk) disable iff (!aresetn)
    hit_now && !stop_det && !lost |=> trx_q == $past(rx_q[0]) && data_line_pin_enable == ack_on;
  endproperty
  a_slv_trx: assert property (p_slv_trx) else $error("slave direction or ack wrong");
  property p_mst_trx;
    @(posedge aclk) disable iff (!aresetn)
    m_acked && !free_w && !stop_det && !lost |=> trx_q != $past(tx_q[0]);
  endproperty
  a_mst_trx: assert property (p_mst_trx) else $error("master direction not inverted");
endmodule : ibcrc_top

// ===== verification/ibcrc_bus_model.sv
// far-side bus model: acknowledging receiver that can stretch the clock low or cut its high short
`timescale 1ns/1ns
module ibcrc_bus_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [3:0] ack_bit,
  input  wire logic [7:0] stretch,
  input  wire logic [3:0] cut,
  output logic            scl_low,
  output logic            sda_low
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt_q;
  logic [7:0] hold_q;
  logic [3:0] cut_q;
  wire        fall_w  = scl_q & ~scl;
  wire        rise_w  = ~scl_q & scl;
  wire        start_w = scl & sda_q & ~sda;
  always_ff @(posedge aclk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!aresetn || start_w) cnt_q <= 4'h0;
    else if (fall_w) cnt_q <= (cnt_q == ack_bit) ? 4'h1 : cnt_q + 4'h1;
    // stretching only adds to the device's own low time, so low stays >= 5 cycles
    // a cut pulls the clock low after cut+1 high cycles, as a faster master would
    if (!aresetn) cut_q <= 4'h0;
    else if (rise_w) cut_q <= cut;
    else if (cut_q != 4'h0) cut_q <= cut_q - 4'h1;
    if (!aresetn) hold_q <= 8'h00;
    else if (cut_q == 4'h1) hold_q <= 8'h08;
    else if (fall_w && hold_q == 8'h00) hold_q <= stretch;
    else if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
  end
  assign scl_low = hold_q != 8'h00;
  assign sda_low = aresetn && ack_bit != 4'h0 && cnt_q == ack_bit;
endmodule : ibcrc_bus_model

// ===== verification/tb.sv
// self-checking bench: register access, word framing, clock timing and role bits
`timescale 1ns/1ns
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  ack_bit = 4'h0;
  logic [3:0]  cut = 4'h0;
  logic [7:0]  stretch = 8'h00;
  wire         awready, wready, bvalid, arready, rvalid, scl_v, scl_en, sda_v, sda_en, irq, m_scl, m_sda;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  // pulled-up wires: anyone driving low wins
  wire         scl = ~(scl_en | m_scl);
  wire         sda = ~(sda_en | m_sda);
  int          fails = 0, total_checks = 0, falls = 0, run = 0, lo_len = 0, i, f0 = 0, hi_run = 0, hi_len = 0;
  logic        scl_q = 1'b1;
  logic [1:0]  resp;
  logic [31:0] rd;
  logic [2:0]  rate;
  logic [7:0]  c1;
  always #50 aclk = ~aclk;
  ibcrc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clock_line_pin_level(scl),
    .clock_line_pin_value(scl_v), .clock_line_pin_enable(scl_en), .data_line_pin_level(sda),
    .data_line_pin_value(sda_v), .data_line_pin_enable(sda_en), .transfer_irq(irq));
  ibcrc_bus_model mdl (.aclk(aclk), .aresetn(aresetn), .scl(scl), .sda(sda), .ack_bit(ack_bit),
    .stretch(stretch), .cut(cut), .scl_low(m_scl), .sda_low(m_sda));
  always @(posedge aclk) begin
    scl_q <= scl;
    if (scl_q && !scl) falls <= falls + 1;
    run <= scl_en ? run + 1 : 0;
    if (!scl_en && run != 0) lo_len <= run;
    hi_run <= scl ? hi_run + 1 : 0;
    if (!scl && hi_run != 0) hi_len <= hi_run;
  end
  function automatic int nclk(input logic [2:0] b, input logic a);
    return (b == 3'h0 ? 8 : int'(b)) + int'(a);
  endfunction : nclk
  function automatic int tlow_f(input logic [2:0] r);
    int t[8] = '{12, 14, 18, 26, 42, 74, 138, 266};
    return t[r];
  endfunction : tlow_f
  function automatic int thigh_f(input logic [2:0] r);
    int t[8] = '{9, 11, 15, 23, 39, 71, 135, 263};
    return t[r];
  endfunction : thigh_f
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic tmo;
    fails++;
    $display("CHECK FAILED wait expected done seen timeout");
    final_report();
  endtask : tmo
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    resp = bresp;
    if (k == 100) tmo();
  endtask : axw
  task automatic axr(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
    if (k == 100) tmo();
  endtask : axr
  task automatic wait_irq;
    int k;
    for (k = 0; k < 20000; k++) begin
      @(posedge aclk);
      if (irq === 1'b1) break;
    end
    if (k == 20000) tmo();
  endtask : wait_irq
  task automatic stop_bus;
    axw(8'h04, 8'h90);
    for (i = 0; i < 50; i++) begin
      axr(8'h08);
      if (rd[5] === 1'b0) break;
    end
    if (i == 50) tmo();
    chk("roles after stop", 32'h0, {30'h0, rd[7:6]});
  endtask : stop_bus
  initial begin
    void'($urandom(32'hd154));
    rate = 3'($urandom % 3);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h08);
    chk("status reset", 32'h10, rd);
    axr(8'h20);
    chk("unmapped resp", 32'h2, {30'h0, resp});
    axw(8'h0c, 8'h78);
    c1 = {3'h5, 1'b1, 1'b0, rate};
    axw(8'h00, c1);
    axw(8'h10, 8'ha4);
    ack_bit <= 4'h9;
    f0 = falls;
    axw(8'h04, 8'hf0);
    wait_irq();
    // one fall ends the start hold, then 8 address bits and the ack clock
    chk("address word falls", 32'd10, falls - f0);
    chk("low period", tlow_f(rate), lo_len);
    axr(8'h00);
    chk("bit count after start", {24'h0, c1 & 8'h1f}, rd);
    axr(8'h08);
    chk("roles after address ack", 32'he0, rd);
    chk("clock held low", 32'h1, {31'h0, scl_en});
    axw(8'h00, c1);
    ack_bit <= 4'h6;
    // stretch past the device's own low so that it has to wait for the bus
    stretch <= 8'(tlow_f(rate) + $urandom_range(5, 8));
    f0 = falls;
    axw(8'h10, 8'($urandom));
    wait_irq();
    chk("data word falls", nclk(3'h5, 1'b1), falls - f0);
    chk("high after stretch", 32'h1, {31'h0, hi_len >= thigh_f(rate) && hi_len <= thigh_f(rate) + 4});
    stretch <= 8'h00;
    ack_bit <= 4'h0;
    cut <= 4'($urandom_range(3, 6));
    axw(8'h00, {3'h3, 1'b0, 1'b0, rate});
    f0 = falls;
    axw(8'h10, 8'h3c);
    wait_irq();
    chk("no-ack word falls", nclk(3'h3, 1'b0), falls - f0);
    chk("low after cut", tlow_f(rate), lo_len);
    cut <= 4'h0;
    stop_bus();
    axw(8'h00, c1);
    axw(8'h10, 8'ha5);
    ack_bit <= 4'h9;
    axw(8'h04, 8'hf0);
    wait_irq();
    axr(8'h08);
    chk("roles after read address", 32'ha0, rd);
    ack_bit <= 4'h0;
    axw(8'h10, 8'h00);
    wait_irq();
    axr(8'h08);
    chk("master receiver ack bit", 32'ha0, rd);
    axr(8'h10);
    chk("received word", 32'hff, rd);
    stop_bus();
    final_report();
  end
endmodule : tb
